// ### bench/brsp_ctrl_model.sv
// Controller side model: the free-running input clock pair
module brsp_ctrl_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Clock pair and warnings one cycle ahead of a rise
  output logic k_out,
  output logic k_n_out,
  output logic pre_e_out,
  output logic pre_k_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // Eight system clocks per half period leaves room for the syncs
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt <= 4'h8;
    else
      cnt <= cnt + 4'h1;
  end
  // K# is the inverse of K, so its rise sits mid-cycle
  assign k_out = ~cnt[3];
  assign k_n_out = cnt[3];
  assign pre_e_out = (cnt[2:0] == 3'h7);
  assign pre_k_out = (cnt == 4'hf);
endmodule

// ### bench/brsp_read_port_checker.sv
// Pin-level assertions for the burst read port
module brsp_read_port_checker #(
  parameter int WORD_W = 18,
  parameter int AW = (WORD_W == brsp_pkg::WIDE_W) ?
    brsp_pkg::WIDE_ADDR_W : brsp_pkg::NARROW_ADDR_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched pins
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic read_port_select_n_in,
  input wire logic write_port_select_n_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [WORD_W-1:0] d_in,
  input wire logic [WORD_W/brsp_pkg::LANE_W-1:0] byte_write_select_n_in,
  input wire logic pll_disable_n_in,
  input wire logic [WORD_W-1:0] q_out,
  input wire logic q_oe_n_out
);
  logic [2:0] ks, kns, rss;
  logic [3:0] low_edges;
  logic [5:0] req_hist;
  logic kr, knr, edg, take, took_last;
  assign kr = ks[1] & ~ks[2];
  assign knr = kns[1] & ~kns[2];
  assign edg = kr | knr;
  // A select right after a taken read is refused, so it starts nothing
  assign take = kr && !rss[1] && !took_last;
  // Mirror the pin syncs; count edges while driven, keep taken reads
  // per input clock edge so back-to-back requests do not confuse it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ks <= 3'h0;
      kns <= 3'h0;
      rss <= 3'h7;
      low_edges <= 4'h0;
      req_hist <= 6'h00;
      took_last <= 1'b0;
    end
    else
    begin
      ks <= {ks[1:0], k_in};
      kns <= {kns[1:0], k_n_in};
      rss <= {rss[1:0], read_port_select_n_in};
      if (q_oe_n_out)
        low_edges <= 4'h0;
      else if (edg)
        low_edges <= low_edges + 4'h1;
      if (kr)
        took_last <= take;
      if (edg)
        req_hist <= {req_hist[4:0], take};
    end
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  chk_oe_on_edge: assert property ($changed(q_oe_n_out) |->
    $past(edg) || $past(edg, 2)) else $error("enable moved off an edge");
  chk_q_on_edge: assert property ($changed(q_out) |->
    $past(edg) || $past(edg, 2)) else $error("data moved off an edge");
  chk_float_k_n: assert property ($rose(q_oe_n_out) |->
    $past(knr) || $past(knr, 2)) else $error("float not on K# rise");
  chk_start_high: assert property (
    $fell(q_oe_n_out) && pll_disable_n_in
    |-> $past(knr) || $past(knr, 2)) else $error("word0 not on K#");
  chk_start_low: assert property (
    $fell(q_oe_n_out) && !pll_disable_n_in
    |-> $past(kr) || $past(kr, 2)) else $error("word0 not on K");
  chk_burst_words: assert property ($rose(q_oe_n_out) |->
    low_edges != 4'h0 && low_edges[1:0] == {1'b0, !pll_disable_n_in})
    else $error("burst not four words");
  chk_lat_low: assert property (
    $fell(q_oe_n_out) && !pll_disable_n_in
    |-> req_hist[2]) else $error("short latency wrong");
  chk_lat_high: assert property (
    $fell(q_oe_n_out) && pll_disable_n_in
    |-> req_hist[5]) else $error("long latency wrong");
endmodule
bind brsp_read_port brsp_read_port_checker #(.WORD_W(WORD_W)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .k_in(k_in), .k_n_in(k_n_in),
  .read_port_select_n_in(read_port_select_n_in),
  .write_port_select_n_in(write_port_select_n_in),
  .addr_in(addr_in), .d_in(d_in),
  .byte_write_select_n_in(byte_write_select_n_in),
  .pll_disable_n_in(pll_disable_n_in),
  .q_out(q_out), .q_oe_n_out(q_oe_n_out));

// ### bench/brsp_read_port_tb_top.sv
// Self-checking bench for the burst read port
module brsp_read_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic k, k_n, pre_e, pre_k, oe_n;
  logic rsel_n = 1'b1;
  logic wsel_n = 1'b1;
  logic pll_n = 1'b1;
  logic [18:0] addr = 19'h00000;
  logic [17:0] d = 18'h00000;
  logic [1:0] bw_n = 2'h3;
  logic [17:0] q;
  logic [35:0] q_wide;
  logic oe_wide_n;
  int num_errors = 0;
  int comparisons = 0;
  logic dr_rs [32], dr_ws [32], ex_on [32], ex_oe [32];
  logic [18:0] dr_a [32];
  logic [17:0] dr_d [32], ex_q [32];
  logic [1:0] dr_bw [32];
  // System clock, 10 ns period
  always #5 clk_in = ~clk_in;
  brsp_ctrl_model u_ctrl (.clk_in(clk_in), .rst_in(rst_in), .k_out(k),
    .k_n_out(k_n), .pre_e_out(pre_e), .pre_k_out(pre_k));
  brsp_read_port #(.WORD_W(18)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .k_in(k), .k_n_in(k_n), .read_port_select_n_in(rsel_n),
    .write_port_select_n_in(wsel_n), .addr_in(addr), .d_in(d),
    .byte_write_select_n_in(bw_n), .pll_disable_n_in(pll_n),
    .q_out(q), .q_oe_n_out(oe_n));
  // Wide variant on the same pins, each word and lane set doubled
  brsp_read_port #(.WORD_W(36)) u_dut_wide (.clk_in(clk_in),
    .rst_in(rst_in), .k_in(k), .k_n_in(k_n),
    .read_port_select_n_in(rsel_n), .write_port_select_n_in(wsel_n),
    .addr_in(addr[17:0]), .d_in({d, d}),
    .byte_write_select_n_in({bw_n, bw_n}), .pll_disable_n_in(pll_n),
    .q_out(q_wide), .q_oe_n_out(oe_wide_n));
  function automatic logic [17:0] wd(input int g, input int j);
    // Group and word in both lanes so a lost lane write shows
    return {g[3:0], j[1:0], 3'h5, g[3:0], j[1:0], 3'h3};
  endfunction
  task automatic check(input string s, input logic [17:0] v, x);
    comparisons++;
    if (v !== x)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, x, v);
    end
  endtask
  // Idle address and data pins change every edge so stale values cannot pass
  task automatic clear();
    for (int i = 0; i < 32; i++)
    begin
      dr_rs[i] = 1'b1;
      dr_ws[i] = 1'b1;
      dr_a[i] = 19'(i) ^ 19'h5a5a5;
      dr_d[i] = ~wd(i, i);
      dr_bw[i] = 2'h3;
      ex_on[i] = 1'b0;
      ex_oe[i] = 1'b1;
    end
  endtask
  task automatic rd(input int e, input int ag);
    dr_rs[e] = 1'b0;
    dr_a[e] = 19'(ag * 37);
  endtask
  task automatic wr(input int e, input int ag, input int g, logic [1:0] b);
    dr_ws[e] = 1'b0;
    dr_a[e] = 19'(ag * 37);
    for (int j = 0; j < 4; j++)
    begin
      dr_d[e + 2 + j] = wd(g, j);
      dr_bw[e + 2 + j] = b;
    end
  endtask
  // Upper lane from group hg covers a write with that lane masked
  task automatic burst(input int w0, input int g, input int hg);
    logic [17:0] lo, hi;
    ex_on[w0 - 1] = 1'b1;
    ex_oe[w0 - 1] = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      lo = wd(g, j);
      hi = wd(hg, j);
      ex_on[w0 + j] = 1'b1;
      ex_oe[w0 + j] = 1'b0;
      ex_q[w0 + j] = {hi[17:9], lo[8:0]};
    end
  endtask
  // Edge 0 is a K rise; outputs are judged 6.5 cycles after each rise
  task automatic play(input int n);
    @(negedge clk_in);
    while (pre_k !== 1'b1)
      @(negedge clk_in);
    for (int e = 0; e < n; e++)
    begin
      @(posedge clk_in);
      rsel_n <= dr_rs[e];
      wsel_n <= dr_ws[e];
      addr <= dr_a[e];
      d <= dr_d[e];
      bw_n <= dr_bw[e];
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      if (ex_on[e])
      begin
        check("oe_n", 18'(oe_n), 18'(ex_oe[e]));
        check("oe_wide_n", 18'(oe_wide_n), 18'(ex_oe[e]));
        if (!ex_oe[e])
        begin
          check("q", q, ex_q[e]);
          check("q_wide_lo", q_wide[17:0], ex_q[e]);
          check("q_wide_hi", q_wide[35:18], ex_q[e]);
        end
      end
      @(negedge clk_in);
      while (pre_e !== 1'b1)
        @(negedge clk_in);
    end
  endtask
  task automatic s_full();
    clear();
    @(posedge clk_in);
    pll_n <= 1'b1;
    wr(0, 1, 1, 2'h0);
    rd(8, 1);
    burst(13, 1, 1);
    ex_on[17] = 1'b1;
    play(18);
  endtask
  // Request on the very next K rise is dropped; stream stays driven
  task automatic s_b2b();
    clear();
    wr(0, 2, 2, 2'h0);
    rd(8, 1);
    rd(10, 2);
    rd(12, 2);
    burst(17, 2, 2);
    burst(13, 1, 1);
    ex_on[21] = 1'b1;
    play(22);
  endtask
  // Legacy latency, masked upper lane, write colliding with a read
  task automatic s_low();
    clear();
    @(posedge clk_in);
    pll_n <= 1'b0;
    wr(0, 1, 3, 2'h2);
    wr(8, 1, 4, 2'h0);
    rd(8, 1);
    rd(16, 1);
    burst(10, 3, 1);
    burst(18, 3, 1);
    ex_on[15] = 1'b1;
    ex_on[23] = 1'b1;
    play(24);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset for 16 cycles, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    s_full();
    s_b2b();
    s_low();
    conclude();
  end
  // Watchdog far beyond the few hundred cycles the run needs
  initial
  begin
    #50us;
    num_errors++;
    conclude();
  end
endmodule

// ### logic/brsp_read_port.sv
// Read side of a pipelined four-word burst SRAM with its write capture
//
// Function
// - Latency two and a half cycles, PLL enabled
// - Latency one cycle when PLL disabled
// - Requests sampled only on positive clock rise
// - Write data and controls registered both edges
// - Read data launched from registers, both edges
// - Four words per access in two cycles
// - Four word arrays, one address per group
// - Active-low read select at K rise starts read
// - Read address stored in read address register
// - First word after two K rises, on K#, PLL enabled
// - Remaining words on alternate edges, ascending
// - Read back-to-back with previous is ignored
// - Deselect still finishes pending bursts
// - Outputs float after next K# rise
// - Read and write share one address bus
// - Separate data inputs and outputs, no turnaround
module brsp_read_port #(
  parameter int WORD_W = 18
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Input clock pair from the controller
  input wire logic k_in,
  input wire logic k_n_in,
  // Port selects and shared address
  input wire logic read_port_select_n_in,
  input wire logic write_port_select_n_in,
  input wire logic [(WORD_W == brsp_pkg::WIDE_W ?
    brsp_pkg::WIDE_ADDR_W : brsp_pkg::NARROW_ADDR_W)-1:0] addr_in,
  // Write data port
  input wire logic [WORD_W-1:0] d_in,
  input wire logic [WORD_W/brsp_pkg::LANE_W-1:0] byte_write_select_n_in,
  // Mode strap
  input wire logic pll_disable_n_in,
  // Read data port
  output logic [WORD_W-1:0] q_out,
  output logic q_oe_n_out
);
  localparam int ADDR_W = (WORD_W == brsp_pkg::WIDE_W) ?
    brsp_pkg::WIDE_ADDR_W : brsp_pkg::NARROW_ADDR_W;
  localparam int BWS_W = WORD_W / brsp_pkg::LANE_W;
  localparam int GROUP_W = brsp_pkg::BURST_LEN * WORD_W;
  localparam int LANES = GROUP_W / brsp_pkg::LANE_W;

  // Pin sampling
  brsp_pkg::brsp_pins_t pin_now;
  brsp_pkg::brsp_pins_t pin_s1;
  brsp_pkg::brsp_pins_t pin_s2;
  logic k_s3;
  logic kn_s3;
  logic k_rise;
  logic kn_rise;
  logic edge_any;

  // Read request and schedule
  logic rd_req;
  logic rd_last;
  logic [ADDR_W-1:0] rd_addr;
  logic mem_rd_en;
  logic mem_rd_valid;
  logic [GROUP_W-1:0] mem_rd_data;
  logic [brsp_pkg::SCHED_W-1:0] sched;
  logic burst_start;

  // FIFO handshakes
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [GROUP_W-1:0] fifo_out_data;

  // Output sequencer
  brsp_pkg::brsp_out_state_t out_state;
  logic [GROUP_W-1:0] burst_data;
  logic [1:0] beat;

  // Write capture
  logic wr_req;
  logic wr_last;
  logic wr_pend;
  logic wr_active;
  logic [ADDR_W-1:0] wr_addr_req;
  logic [ADDR_W-1:0] wr_addr;
  logic [1:0] wr_beat;
  logic [GROUP_W-1:0] wr_group;
  logic [LANES-1:0] wr_lanes;
  logic mem_we;

  // Bundle the pins; narrow fields are zero padded to the widest variant
  always_comb
  begin
    pin_now = '0;
    pin_now.k = k_in;
    pin_now.k_n = k_n_in;
    pin_now.read_port_select_n = read_port_select_n_in;
    pin_now.write_port_select_n = write_port_select_n_in;
    pin_now.pll_disable_n = pll_disable_n_in;
    pin_now.addr = brsp_pkg::NARROW_ADDR_W'(addr_in);
    pin_now.d = brsp_pkg::MAX_W'(d_in);
    pin_now.byte_write_select_n = brsp_pkg::MAX_BWS'(byte_write_select_n_in);
  end

  // Two-stage synchroniser for every pin, then one more stage of the
  // clocks for edge detection; data and clocks stay aligned
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      k_s3 <= 1'b0;
      kn_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_now;
      pin_s2 <= pin_s1;
      k_s3 <= pin_s2.k;
      kn_s3 <= pin_s2.k_n;
    end
  end

  // Only rising edges of either input clock matter
  assign k_rise = pin_s2.k && !k_s3;
  assign kn_rise = pin_s2.k_n && !kn_s3;
  assign edge_any = k_rise || kn_rise;

  // Read accepted on K rise only, never right after another read;
  // a full FIFO also refuses it so nothing is lost downstream
  assign rd_req = k_rise && !pin_s2.read_port_select_n && !rd_last
    && fifo_in_ready;

  // Remember whether the previous K rise took a read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_last <= 1'b0;
    else if (k_rise)
      rd_last <= rd_req;
  end

  // Read address register taken from the shared bus, then array read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_addr <= '0;
      mem_rd_en <= 1'b0;
      mem_rd_valid <= 1'b0;
    end
    else
    begin
      if (rd_req)
        rd_addr <= pin_s2.addr[ADDR_W-1:0];
      mem_rd_en <= rd_req;
      mem_rd_valid <= mem_rd_en;
    end
  end

  // One address selects a whole four-word group
  brsp_array #(
    .DATA_W(GROUP_W),
    .ADDR_W(ADDR_W),
    .LANE_W(brsp_pkg::LANE_W)
  ) u_array (
    .clk_in(clk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(wr_addr),
    .wr_data_in(wr_group),
    .wr_lane_en_in(wr_lanes),
    .rd_en_in(mem_rd_en),
    .rd_addr_in(rd_addr),
    .rd_data_out(mem_rd_data)
  );

  // Groups wait here until their output slot comes round
  brsp_fifo #(
    .WIDTH(GROUP_W),
    .DEPTH(brsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(mem_rd_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(mem_rd_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // Latency shift register advanced on every input clock edge; keeps
  // going after deselect so pending bursts still come out
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      sched <= '0;
    else if (edge_any)
      sched <= {sched[brsp_pkg::SCHED_W-2:0], rd_req};
  end

  // Tap chosen by the PLL strap: five edges, or two in legacy mode
  always_comb
  begin
    if (pin_s2.pll_disable_n)
      burst_start = edge_any
        && sched[brsp_pkg::LAT_FULL_HALVES-1];
    else
      burst_start = edge_any
        && sched[brsp_pkg::LAT_LEGACY_HALVES-1];
  end

  // Pop the group at the moment its first word is launched
  assign fifo_out_ready = burst_start;

  // Output registers: one word per input clock edge, lowest first,
  // outputs released on the K# rise after the last pending word
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_state <= brsp_pkg::OUT_IDLE;
      burst_data <= '0;
      beat <= brsp_pkg::BEAT_RESET;
      q_out <= brsp_pkg::Q_RESET[WORD_W-1:0];
      q_oe_n_out <= 1'b1;
    end
    else if (burst_start && fifo_out_valid)
    begin
      burst_data <= fifo_out_data;
      q_out <= fifo_out_data[WORD_W-1:0];
      q_oe_n_out <= 1'b0;
      beat <= 2'h1;
      out_state <= brsp_pkg::OUT_BURST;
    end
    else if (edge_any)
    begin
      unique case (out_state)
        brsp_pkg::OUT_IDLE:
        begin
          q_oe_n_out <= 1'b1;
        end
        brsp_pkg::OUT_BURST:
        begin
          q_out <= burst_data[beat*WORD_W +: WORD_W];
          beat <= beat + 2'h1;
          if (beat == brsp_pkg::LAST_BEAT)
            out_state <= brsp_pkg::OUT_HOLD;
        end
        brsp_pkg::OUT_HOLD:
        begin
          if (kn_rise)
          begin
            q_oe_n_out <= 1'b1;
            out_state <= brsp_pkg::OUT_IDLE;
          end
        end
        default:
        begin
          out_state <= brsp_pkg::OUT_IDLE;
        end
      endcase
    end
  end

  // Write accepted on K rise, not right after another write, and only
  // when no read takes the shared address bus at that edge
  assign wr_req = k_rise && !pin_s2.write_port_select_n && !wr_last
    && !rd_req;

  // Remember whether the previous K rise took a write
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wr_last <= 1'b0;
    else if (k_rise)
      wr_last <= wr_req;
  end

  // Write address held until its data phase begins
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_addr_req <= '0;
      wr_pend <= 1'b0;
    end
    else if (wr_req)
    begin
      wr_addr_req <= pin_s2.addr[ADDR_W-1:0];
      wr_pend <= 1'b1;
    end
    else if (k_rise && !wr_active)
      wr_pend <= 1'b0;
  end

  // Input registers on K and K# rises, each word with its lane enables
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_active <= 1'b0;
      wr_beat <= brsp_pkg::BEAT_RESET;
      wr_addr <= '0;
      wr_group <= '0;
      wr_lanes <= '0;
      mem_we <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      if (k_rise && wr_pend && !wr_active)
      begin
        wr_addr <= wr_addr_req;
        wr_group[WORD_W-1:0] <= pin_s2.d[WORD_W-1:0];
        wr_lanes[BWS_W-1:0] <= ~pin_s2.byte_write_select_n[BWS_W-1:0];
        wr_beat <= 2'h1;
        wr_active <= 1'b1;
      end
      else if (edge_any && wr_active)
      begin
        wr_group[wr_beat*WORD_W +: WORD_W] <= pin_s2.d[WORD_W-1:0];
        wr_lanes[wr_beat*BWS_W +: BWS_W] <=
          ~pin_s2.byte_write_select_n[BWS_W-1:0];
        wr_beat <= wr_beat + 2'h1;
        if (wr_beat == brsp_pkg::LAST_BEAT)
        begin
          wr_active <= 1'b0;
          mem_we <= 1'b1;
        end
      end
    end
  end
endmodule

// ### logic/brsp_store.sv
// Burst group array and read data FIFO of the burst read port

// Group array with one write port, byte lane enables, registered read
module brsp_array #(
  parameter int DATA_W = 72,
  parameter int ADDR_W = 19,
  parameter int LANE_W = 9
) (
  // Clock
  input wire logic clk_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [DATA_W/LANE_W-1:0] wr_lane_en_in,
  // Read side
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);
  localparam int LANES = DATA_W / LANE_W;

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // One write process per byte lane so untouched lanes keep their data
  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    always_ff @(posedge clk_in)
    begin
      if (wr_en_in && wr_lane_en_in[g])
      begin
        mem[wr_addr_in][g*LANE_W +: LANE_W] <= wr_data_in[g*LANE_W +: LANE_W];
      end
    end
  end

  // Registered read; no reset so the array maps onto block memory
  always_ff @(posedge clk_in)
  begin
    if (rd_en_in)
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// Small synchronous FIFO with valid and ready on both sides
module brsp_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = store[rd_ptr];

  // Storage
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data_in;
    end
  end

  // Pointers and count; wrap relies on a power-of-two depth
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ### shared/brsp_pkg.sv
// Shared constants, types and state codes of the burst read port
package brsp_pkg;

  // Word widths of the two variants and the byte lane width
  localparam int NARROW_W = 18;
  localparam int WIDE_W = 36;
  localparam int MAX_W = 36;
  localparam int LANE_W = 9;
  localparam int MAX_BWS = 4;

  // Words per burst and group address widths of the two variants
  localparam int BURST_LEN = 4;
  localparam int NARROW_ADDR_W = 19;
  localparam int WIDE_ADDR_W = 18;

  // Read latency counted in input clock edges (K and K# rises)
  localparam int LAT_FULL_HALVES = 5;
  localparam int LAT_LEGACY_HALVES = 2;
  localparam int SCHED_W = 5;

  // Depth of the read data FIFO
  localparam int FIFO_DEPTH = 8;

  // Reset values and the last beat index
  localparam logic [MAX_W-1:0] Q_RESET = 36'h000000000;
  localparam logic [1:0] BEAT_RESET = 2'h0;
  localparam logic [1:0] LAST_BEAT = 2'h3;

  // Input pins as one sampled bundle
  typedef struct packed {
    logic k;
    logic k_n;
    logic read_port_select_n;
    logic write_port_select_n;
    logic pll_disable_n;
    logic [NARROW_ADDR_W-1:0] addr;
    logic [MAX_W-1:0] d;
    logic [MAX_BWS-1:0] byte_write_select_n;
  } brsp_pins_t;

  // Output sequencer states
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_BURST = 2'b01,
    OUT_HOLD = 2'b10
  } brsp_out_state_t;

endpackage
